// ==== src/analog_comparator_control.v ====
// Implementation choice: the AXI4-Lite interface to the registers.
`include "comparator_defs.vh"

module analog_comparator_control (
   input  wire        aclk,
   input  wire        aresetn,
   // AXI4-Lite slave
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Analog front end
   input  wire        raw_compare,
   output reg         bandgap_select,
   output reg         use_channel,
   output reg  [2:0]  channel_select_out,
   output reg         comparator_power_off,
   // Surrounding system
   input  wire        converter_enable,
   input  wire [2:0]  channel_select,
   input  wire        global_irq_enable,
   input  wire        irq_vector_ack,
   input  wire        positive_pin_in,
   input  wire        negative_pin_in,
   output reg         positive_pin_read,
   output reg         negative_pin_read,
   output reg         capture_input,
   output reg         compare_irq
);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg        sync_a_r;
   reg        result_r;
   reg        result_prev_r;
   reg        power_off_r;
   reg        bandgap_r;
   reg        flag_r;
   reg        irq_en_r;
   reg        route_r;
   reg  [1:0] mode_r;
   reg        mux_en_r;
   reg  [2:0] trig_src_r;
   reg        pos_dis_r;
   reg        neg_dis_r;
   reg        aw_got_r;
   reg        w_got_r;
   reg  [7:0] aw_addr_r;
   reg  [7:0] w_byte_r;
   reg        w_strb_r;

   wire       do_write;
   wire       wr_ctrl;
   wire       event_hit;
   reg        flag_nxt;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   function mapped;
      input [7:0] a;
      begin
         mapped = (a == `OFF_CTRL_STATUS) || (a == `OFF_CONV_CTRL_B) ||
                  (a == `OFF_DIN_DISABLE);
      end
   endfunction

   // ----------------------------------------
   // Result synchroniser and edge detection
   // ----------------------------------------
   // Analog compare is done outside; raw_compare is high when positive > negative
   always @(posedge aclk) begin
      if (!aresetn) begin
         sync_a_r      <= 1'b0;
         result_r      <= 1'b0;
         result_prev_r <= 1'b0;
      end else begin
         sync_a_r      <= raw_compare & ~power_off_r;
         result_r      <= sync_a_r;
         result_prev_r <= result_r;
      end
   end

   function edge_match;
      input [1:0] mode;
      input       cur;
      input       prev;
      begin
         case (mode)
            `MODE_TOGGLE: edge_match = cur ^ prev;
            `MODE_FALL:   edge_match = ~cur & prev;
            `MODE_RISE:   edge_match = cur & ~prev;
            default:      edge_match = 1'b0;
         endcase
      end
   endfunction

   assign event_hit = edge_match(mode_r, result_r, result_prev_r);

   // ----------------------------------------
   // Write channel
   // ----------------------------------------
   assign do_write = aw_got_r && w_got_r && !s_axi_bvalid;
   assign wr_ctrl  = do_write && w_strb_r && (aw_addr_r == `OFF_CTRL_STATUS);

   always @* begin
      flag_nxt = flag_r;
      if (irq_vector_ack)
         flag_nxt = 1'b0;
      if (wr_ctrl && w_byte_r[`BIT_EVENT_FLAG])
         flag_nxt = 1'b0;
      if (event_hit)
         flag_nxt = 1'b1;
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
         aw_got_r      <= 1'b0;
         w_got_r       <= 1'b0;
         aw_addr_r     <= `RST_BYTE;
         w_byte_r      <= `RST_BYTE;
         w_strb_r      <= 1'b0;
         power_off_r   <= 1'b0;
         bandgap_r     <= 1'b0;
         flag_r        <= 1'b0;
         irq_en_r      <= 1'b0;
         route_r       <= 1'b0;
         mode_r        <= `MODE_TOGGLE;
         mux_en_r      <= 1'b0;
         trig_src_r    <= 3'h0;
         pos_dis_r     <= 1'b0;
         neg_dis_r     <= 1'b0;
      end else begin
         flag_r        <= flag_nxt;
         s_axi_awready <= !aw_got_r && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_got_r && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r  <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_r  <= 1'b1;
            w_byte_r <= s_axi_wdata[7:0];
            w_strb_r <= s_axi_wstrb[0];
         end
         if (do_write) begin
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(aw_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
            if (w_strb_r) begin
               case (aw_addr_r)
                  `OFF_CTRL_STATUS: begin
                     power_off_r <= w_byte_r[`BIT_POWER_OFF];
                     bandgap_r   <= w_byte_r[`BIT_BANDGAP];
                     irq_en_r    <= w_byte_r[`BIT_IRQ_ENABLE];
                     route_r     <= w_byte_r[`BIT_CAPTURE_ROUTE];
                     mode_r      <= w_byte_r[`BIT_MODE_HIGH:`BIT_MODE_LOW];
                  end
                  `OFF_CONV_CTRL_B: begin
                     mux_en_r   <= w_byte_r[`BIT_MUX_ENABLE];
                     trig_src_r <= w_byte_r[2:0];
                  end
                  `OFF_DIN_DISABLE: begin
                     neg_dis_r <= w_byte_r[1];
                     pos_dis_r <= w_byte_r[0];
                  end
                  default: begin
                     pos_dis_r <= pos_dis_r;
                  end
               endcase
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Read channel
   // ----------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= `RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
            case (s_axi_araddr)
               `OFF_CTRL_STATUS:
                  s_axi_rdata <= {24'h0, power_off_r, bandgap_r, result_r, flag_r,
                                  irq_en_r, route_r, mode_r};
               `OFF_CONV_CTRL_B:
                  s_axi_rdata <= {24'h0, 1'b0, mux_en_r, 3'h0, trig_src_r};
               `OFF_DIN_DISABLE:
                  s_axi_rdata <= {24'h0, 6'h00, neg_dis_r, pos_dis_r};
               default:
                  s_axi_rdata <= 32'h0;
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Outputs to analog, port, timer and interrupt
   // ----------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         bandgap_select       <= 1'b0;
         use_channel          <= 1'b0;
         channel_select_out   <= 3'h0;
         comparator_power_off <= 1'b0;
         positive_pin_read    <= 1'b0;
         negative_pin_read    <= 1'b0;
         capture_input        <= 1'b0;
         compare_irq          <= 1'b0;
      end else begin
         bandgap_select       <= bandgap_r;
         use_channel          <= mux_en_r & ~converter_enable;
         channel_select_out   <= channel_select;
         comparator_power_off <= power_off_r;
         positive_pin_read    <= positive_pin_in & ~pos_dis_r;
         negative_pin_read    <= negative_pin_in & ~neg_dis_r;
         capture_input        <= route_r & result_r;
         compare_irq          <= flag_nxt & irq_en_r & global_irq_enable;
      end
   end

endmodule

// ==== src/comparator_defs.vh ====
// How it works
// - Result high when positive input exceeds negative
// - Mux enable and converter off pick channel
// - Bandgap select replaces positive pin input
// - Result synchronised, one to two cycles late
// - Chosen edge of result sets event flag
// - Mode 00 toggle, 01 reserved, 10 fall, 11 rise
// - Irq when flag, enable and global enable
// - Vector acknowledge clears the event flag
// - Writing one clears flag, zero keeps
// - Capture route feeds result to timer capture
// - Route off: no capture connection
// - Power-off bit removes comparator power
// - Buffer disable forces port bit to zero
// - Upper six disable bits read zero
`ifndef COMPARATOR_DEFS_VH
`define COMPARATOR_DEFS_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define OFF_CTRL_STATUS   8'h50
`define OFF_CONV_CTRL_B   8'h7b
`define OFF_DIN_DISABLE   8'h7f

// ----------------------------------------
// Control/status and conversion control B field positions
// ----------------------------------------
`define BIT_POWER_OFF     7
`define BIT_BANDGAP       6
`define BIT_RESULT        5
`define BIT_EVENT_FLAG    4
`define BIT_IRQ_ENABLE    3
`define BIT_CAPTURE_ROUTE 2
`define BIT_MODE_HIGH     1
`define BIT_MODE_LOW      0
`define BIT_MUX_ENABLE    6

// ----------------------------------------
// Event modes, reset value and bus response codes
// ----------------------------------------
`define MODE_TOGGLE       2'b00
`define MODE_RESERVED     2'b01
`define MODE_FALL         2'b10
`define MODE_RISE         2'b11
`define RST_BYTE          8'h00
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

// ==== tb/analog_comparator_control_props.sv ====
module comparator_props (
   input logic       aclk,
   input logic       aresetn,
   input logic       s_axi_awvalid,
   input logic       s_axi_awready,
   input logic       s_axi_wvalid,
   input logic       s_axi_wready,
   input logic [1:0] s_axi_bresp,
   input logic       s_axi_bvalid,
   input logic       s_axi_bready,
   input logic       s_axi_arvalid,
   input logic       s_axi_arready,
   input logic       s_axi_rvalid,
   input logic       s_axi_rready,
   input logic       raw_compare,
   input logic       use_channel,
   input logic       comparator_power_off,
   input logic       converter_enable,
   input logic       global_irq_enable,
   input logic       positive_pin_in,
   input logic       positive_pin_read,
   input logic       capture_input,
   input logic       compare_irq
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ----------------------------------------
   // Bus handshakes
   // ----------------------------------------
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_off;
      comparator_power_off [*4];
   endsequence
   property p_write; s_wr_taken |-> ##[1:2] s_axi_bvalid; endproperty
   a_write: assert property (p_write) else $error("write response missing");
   property p_read; s_rd_taken |=> s_axi_rvalid; endproperty
   a_read: assert property (p_read) else $error("read data late");
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");
   property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
   a_rhold: assert property (p_rhold) else $error("read data dropped");
   // ----------------------------------------
   // Comparator outputs
   // ----------------------------------------
   property p_irq; compare_irq |-> global_irq_enable || $past(global_irq_enable); endproperty
   a_irq: assert property (p_irq) else $error("irq without global enable");
   property p_mux; use_channel |-> !converter_enable || !$past(converter_enable); endproperty
   a_mux: assert property (p_mux) else $error("channel used while converter on");
   property p_buf; positive_pin_read |-> positive_pin_in || $past(positive_pin_in); endproperty
   a_buf: assert property (p_buf) else $error("pin read without pin high");
   property p_cap;
      capture_input |-> $past(raw_compare) || $past(raw_compare, 2) || $past(raw_compare, 3);
   endproperty
   a_cap: assert property (p_cap) else $error("capture without result");
   property p_pwr; s_off |-> !capture_input; endproperty
   a_pwr: assert property (p_pwr) else $error("result while powered off");
endmodule
bind analog_comparator_control comparator_props comparator_props_i (.*);

// ==== tb/test_analog_comparator_control.sv ====
`include "comparator_defs.vh"
module test_analog_comparator_control;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [1:0] m; logic b, a, f;} row_t;
   localparam logic [7:0] ctl = `OFF_CTRL_STATUS;
   localparam logic [7:0] cvb = `OFF_CONV_CTRL_B;
   localparam logic [7:0] din = `OFF_DIN_DISABLE;
   logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0, raw_compare = 0, converter_enable = 1;
   logic        global_irq_enable = 1, irq_vector_ack = 0, positive_pin_in = 0;
   logic        negative_pin_in = 0;
   logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0;
   logic [3:0]  s_axi_wstrb = 0;
   logic [2:0]  channel_select = 0;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   wire         bandgap_select, use_channel, comparator_power_off, positive_pin_read;
   wire         negative_pin_read, capture_input, compare_irq;
   wire  [2:0]  channel_select_out;
   int          n_errors = 0, n_tests = 0;
   // Mode, result before, result after, expected flag
   row_t        rows [7] = '{5'h03, 5'h05, 5'h0a, 5'h15, 5'h12, 5'h1b, 5'h1c};

   analog_comparator_control analog_comparator_control_i (.*);
   always #20 aclk = ~aclk;
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_pin(input logic got, input logic exp);
      chk_reg({31'h0, got}, {31'h0, exp});
   endtask
   task automatic limit(input int n);
      if (n >= 50) begin
         n_errors++;
         print_verdict();
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge aclk);
   endtask
   task automatic done(input string s);
      $display("test %s done", s);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, v};
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (s_axi_bvalid !== 1'b1 && n < 50);
      s_axi_bready <= 0;
      limit(n);
      if (a == ctl || a == cvb || a == din)
         chk_reg({30'h0, s_axi_bresp}, {30'h0, `RESP_OKAY});
      else
         chk_reg({30'h0, s_axi_bresp}, {30'h0, `RESP_SLVERR});
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (s_axi_rvalid !== 1'b1 && n < 50);
      s_axi_rready <= 0;
      limit(n);
      chk_reg(s_axi_rdata, exp);
      chk_reg({30'h0, s_axi_rresp}, {30'h0, er});
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      tick(3);
      aresetn <= 1;
      rdc(ctl, 32'h0, `RESP_OKAY);
      rdc(cvb, 32'h0, `RESP_OKAY);
      rdc(din, 32'h0, `RESP_OKAY);
      done("reset");
      foreach (rows[i]) begin
         wr(ctl, {6'h00, rows[i].m});
         raw_compare <= rows[i].b;
         tick(5);
         wr(ctl, {6'h04, rows[i].m});
         raw_compare <= rows[i].a;
         tick(5);
         rdc(ctl, {26'h0, rows[i].a, rows[i].f, 2'b00, rows[i].m}, 0);
      end
      done("event modes");
      raw_compare <= 1;
      tick(5);
      wr(ctl, 8'h0b);
      tick(2);
      chk_pin(compare_irq, 1);
      global_irq_enable <= 0;
      tick(2);
      chk_pin(compare_irq, 0);
      global_irq_enable <= 1;
      irq_vector_ack <= 1;
      tick(1);
      irq_vector_ack <= 0;
      tick(2);
      chk_pin(compare_irq, 0);
      rdc(ctl, 32'h2b, 0);
      done("interrupt");
      wr(ctl, 8'h07);
      tick(4);
      chk_pin(capture_input, 1);
      raw_compare <= 0;
      tick(4);
      chk_pin(capture_input, 0);
      raw_compare <= 1;
      wr(ctl, 8'h03);
      tick(4);
      chk_pin(capture_input, 0);
      done("capture");
      wr(ctl, 8'hc3);
      tick(4);
      chk_pin(bandgap_select, 1);
      chk_pin(comparator_power_off, 1);
      rdc(ctl, 32'hd3, 0);
      wr(ctl, 8'h13);
      tick(2);
      chk_pin(bandgap_select, 0);
      chk_pin(comparator_power_off, 0);
      done("power");
      wr(cvb, 8'hff);
      rdc(cvb, 32'h47, 0);
      converter_enable <= 0;
      channel_select <= 3'h5;
      tick(2);
      chk_pin(use_channel, 1);
      chk_reg({29'h0, channel_select_out}, 32'h5);
      converter_enable <= 1;
      tick(2);
      chk_pin(use_channel, 0);
      done("mux");
      positive_pin_in <= 1;
      negative_pin_in <= 1;
      tick(2);
      chk_reg({30'h0, negative_pin_read, positive_pin_read}, 32'h3);
      wr(din, 8'hff);
      rdc(din, 32'h3, 0);
      tick(2);
      chk_reg({30'h0, negative_pin_read, positive_pin_read}, 32'h0);
      wr(8'h20, 8'hff);
      rdc(8'h20, 32'h0, `RESP_SLVERR);
      done("buffers and unmapped");
      print_verdict();
   end
endmodule
